// [rtl/pwmo_pkg.sv]
// constants, field positions and types of the pwm operator slice
// assumes an ahb-lite slave with 32-bit words at byte offsets 0x90..0xb8
package pwmo_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] DT_CFG_OFF = 8'h90;
   localparam logic [7:0] FED_SHD_OFF = 8'h94;
   localparam logic [7:0] RED_SHD_OFF = 8'h98;
   localparam logic [7:0] CR_CFG_OFF = 8'h9c;
   localparam logic [7:0] FA_CFG_OFF = 8'ha0;
   localparam logic [7:0] FF_CFG_OFF = 8'ha4;
   localparam logic [7:0] TS_OFF = 8'ha8;
   localparam logic [7:0] SU_CFG_OFF = 8'hac;
   localparam logic [7:0] STA_SHD_OFF = 8'hb0;
   localparam logic [7:0] STB_SHD_OFF = 8'hb4;
   localparam logic [7:0] GT_CFG_OFF = 8'hb8;
   // ==========================================
   // field positions
   localparam int DT_FED_UP_LSB = 0;
   localparam int DT_RED_UP_LSB = 4;
   localparam int DT_DEB = 8;
   localparam int DT_ASWAP = 9;
   localparam int DT_BSWAP = 10;
   localparam int DT_REDIN = 11;
   localparam int DT_FEDIN = 12;
   localparam int DT_REDINV = 13;
   localparam int DT_FEDINV = 14;
   localparam int DT_ABYP = 15;
   localparam int DT_BBYP = 16;
   localparam int DT_CLKSEL = 17;
   localparam int CR_EN = 0;
   localparam int CR_PRE_LSB = 1;
   localparam int CR_DUTY_LSB = 5;
   localparam int CR_FPW_LSB = 8;
   localparam int CR_OINV = 12;
   localparam int CR_IINV = 13;
   localparam int FA_CBC_EN_LSB = 0;
   localparam int FA_SW_CBC = 3;
   localparam int FA_OST_EN_LSB = 4;
   localparam int FA_SW_OST = 7;
   localparam int FA_ACT_LSB = 8;
   localparam int FA_ACT_STRIDE = 8;
   localparam int FF_CLR = 0;
   localparam int FF_REF_LSB = 1;
   localparam int FF_FCBC = 3;
   localparam int FF_FOST = 4;
   localparam int TS_CBC_ON = 0;
   localparam int TS_OST_ON = 1;
   localparam int SU_A_LSB = 0;
   localparam int SU_B_LSB = 4;
   localparam int SU_A_PEND = 8;
   localparam int SU_B_PEND = 9;
   localparam int GT_UP_LSB = 0;
   localparam int GT_T0_LSB = 4;
   localparam int GT_T1_LSB = 7;
   localparam int UPM_TEZ = 0;
   localparam int UPM_TEP = 1;
   localparam int UPM_SYNC = 2;
   localparam int UPM_OFF = 3;
   // ==========================================
   // reset values and codes
   localparam logic [31:0] DT_CFG_RST = 32'h0001_8000;
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;
   localparam logic [1:0] ACT_HOLD = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [2:0] TRIG_SYNC = 3'h3;
   localparam logic [2:0] CR_LAST_PHASE = 3'h7;
   typedef struct packed {
      logic timer_equals_zero;
      logic timer_equals_period;
      logic sync_taken;
      logic timer_up;
   } pwmo_timer_type;
endpackage

// [rtl/pwmo_top.sv]
// pwm operator slice: dead time, carrier chopper, fault handler,
// time-stamp shadows and generator trigger selection behind ahb-lite
// assumes generator, timer and fault detectors run on hclk
//
// Overview of operation
// - dead-time counts every hclk, or only on prescaled timer ticks when selected
// - dual-edge mode off: delays on separate paths; on: both on path b
// - rising/falling delay actives load per own 4-bit update method
// - delay writes go to shadows; logic uses only active copies
// - carrier input invert flips both outputs entering the carrier
// - carrier output invert flips both outputs leaving the carrier
// - first pulse of a burst lasts first-pulse-width carrier periods
// - carrier duty is duty field over eight
// - carrier period is eight hclk periods times prescale plus one
// - carrier enabled modulates; disabled passes signals unchanged
// - fault action per output, trip type, direction: hold, low, high, toggle
// - each fault input starts one-shot trip only when enabled
// - each fault input starts cycle trip only when enabled
// - software forced trips act only with their software enable set
// - any change of force-one-shot bit starts a one-shot trip
// - any change of force-cycle bit starts a cycle trip
// - cycle trip refreshed at zero (bit0) and/or period (bit1)
// - any change of clear-one-shot bit ends the one-shot trip
// - two read-only flags show one-shot and cycle trips ongoing
// - stamp pending flag set on shadow write, cleared on active load
// - stamp actives load per own 4-bit update method
// - trigger sources select fault 0-2, sync 3, none otherwise, registered one hclk later
// - generator config active loads per its update method
`timescale 1ns/1ps
module pwmo_top
   import pwmo_pkg::*;
#(
   parameter int VAL_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic op1_gen_a,
   input wire logic op1_gen_b,
   input wire logic [2:0] fault_input,
   input wire logic prescaled_timer_clock,
   input wire pwmo_timer_type timer_events,
   output logic op1_output_a,
   output logic op1_output_b,
   output logic gen_trigger0,
   output logic gen_trigger1,
   output logic [VAL_W-1:0] stamp_a_active,
   output logic [VAL_W-1:0] stamp_b_active,
   output logic gen_config_load
);
   // ==========================================
   // ahb-lite slave, zero wait states while clk_en is high, wait states while it is low
   logic take;
   logic wr_q;
   logic valid_q;
   logic [7:0] addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   logic wr_do;
   logic [31:0] dt_q;
   logic [31:0] cr_q;
   logic [31:0] fa_q;
   logic [31:0] ff_q;
   logic [7:0] su_q;
   logic [31:0] gt_q;
   logic [VAL_W-1:0] shd_q [4];
   logic [VAL_W-1:0] act_q [4];
   logic [4:0] upd_wr;
   logic [4:0] upd_pend_q;
   logic [4:0] upd_load;
   logic [3:0] upd_m [5];
   logic ost_on_q;
   logic cbc_on_q;

   // stalling through hreadyout keeps the bus frozen with the block
   assign take = hsel & htrans[1] & hready & clk_en;
   assign hreadyout = clk_en;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign wr_do = valid_q & wr_q & clk_en;

   always_comb begin
      rd_mux = ZERO_RST;
      case (haddr[7:0])
         DT_CFG_OFF: rd_mux = dt_q;
         FED_SHD_OFF: rd_mux[VAL_W-1:0] = shd_q[0];
         RED_SHD_OFF: rd_mux[VAL_W-1:0] = shd_q[1];
         CR_CFG_OFF: rd_mux = cr_q;
         FA_CFG_OFF: rd_mux = fa_q;
         FF_CFG_OFF: rd_mux = ff_q;
         TS_OFF: begin
            rd_mux[TS_CBC_ON] = cbc_on_q;
            rd_mux[TS_OST_ON] = ost_on_q;
         end
         SU_CFG_OFF: begin
            rd_mux[7:0] = su_q;
            rd_mux[SU_A_PEND] = upd_pend_q[2];
            rd_mux[SU_B_PEND] = upd_pend_q[3];
         end
         STA_SHD_OFF: rd_mux[VAL_W-1:0] = shd_q[2];
         STB_SHD_OFF: rd_mux[VAL_W-1:0] = shd_q[3];
         GT_CFG_OFF: rd_mux = gt_q;
         default: rd_mux = ZERO_RST;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         valid_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata_q <= ZERO_RST;
      end else if (clk_en) begin
         valid_q <= take;
         if (take) begin
            wr_q <= hwrite;
            addr_q <= haddr[7:0];
            if (!hwrite) begin
               hrdata_q <= rd_mux;
            end
         end
      end
   end

   // ==========================================
   // software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dt_q <= DT_CFG_RST;
         cr_q <= ZERO_RST;
         fa_q <= ZERO_RST;
         ff_q <= ZERO_RST;
         su_q <= 8'h00;
         gt_q <= ZERO_RST;
         for (int i = 0; i < 4; i++) begin
            shd_q[i] <= '0;
         end
      end else if (wr_do) begin
         case (addr_q)
            DT_CFG_OFF: dt_q <= hwdata;
            FED_SHD_OFF: shd_q[0] <= hwdata[VAL_W-1:0];
            RED_SHD_OFF: shd_q[1] <= hwdata[VAL_W-1:0];
            CR_CFG_OFF: cr_q <= hwdata;
            FA_CFG_OFF: fa_q <= hwdata;
            FF_CFG_OFF: ff_q <= hwdata;
            SU_CFG_OFF: su_q <= hwdata[7:0];
            STA_SHD_OFF: shd_q[2] <= hwdata[VAL_W-1:0];
            STB_SHD_OFF: shd_q[3] <= hwdata[VAL_W-1:0];
            GT_CFG_OFF: gt_q <= hwdata;
            default: dt_q <= dt_q;
         endcase
      end
   end

   // ==========================================
   // shadow to active transfer
   assign upd_wr[0] = wr_do & (addr_q == FED_SHD_OFF);
   assign upd_wr[1] = wr_do & (addr_q == RED_SHD_OFF);
   assign upd_wr[2] = wr_do & (addr_q == STA_SHD_OFF);
   assign upd_wr[3] = wr_do & (addr_q == STB_SHD_OFF);
   assign upd_wr[4] = wr_do & (addr_q == GT_CFG_OFF);
   assign upd_m[0] = dt_q[DT_FED_UP_LSB +: 4];
   assign upd_m[1] = dt_q[DT_RED_UP_LSB +: 4];
   assign upd_m[2] = su_q[SU_A_LSB +: 4];
   assign upd_m[3] = su_q[SU_B_LSB +: 4];
   assign upd_m[4] = gt_q[GT_UP_LSB +: 4];

   for (genvar u = 0; u < 5; u++) begin : g_upd
      logic moment;
      // any selected moment fires the load, so the earliest one wins
      assign moment = (upd_m[u][UPM_TEZ] & timer_events.timer_equals_zero)
                    | (upd_m[u][UPM_TEP] & timer_events.timer_equals_period)
                    | (upd_m[u][UPM_SYNC] & timer_events.sync_taken);
      assign upd_load[u] = upd_pend_q[u] & clk_en
                         & ((upd_m[u] == 4'h0) | (~upd_m[u][UPM_OFF] & moment));
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            upd_pend_q[u] <= 1'b0;
         end else if (upd_wr[u]) begin
            upd_pend_q[u] <= 1'b1;
         end else if (upd_load[u]) begin
            upd_pend_q[u] <= 1'b0;
         end
      end
   end

   for (genvar v = 0; v < 4; v++) begin : g_act
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            act_q[v] <= '0;
         end else if (upd_load[v]) begin
            act_q[v] <= shd_q[v];
         end
      end
   end

   assign stamp_a_active = act_q[2];
   assign stamp_b_active = act_q[3];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gen_config_load <= 1'b0;
      end else if (clk_en) begin
         gen_config_load <= upd_load[4];
      end
   end

   // ==========================================
   // dead-time generator
   logic dt_tick;
   logic red_src;
   logic fed_src;
   logic red_o;
   logic fed_o;
   logic path_a;
   logic path_b;
   logic [1:0] dt_out;
   logic [VAL_W-1:0] red_cnt_q;
   logic [VAL_W-1:0] fed_cnt_q;

   assign dt_tick = dt_q[DT_CLKSEL] ? prescaled_timer_clock : 1'b1;
   assign red_src = dt_q[DT_REDIN] ? op1_gen_b : op1_gen_a;
   assign fed_src = dt_q[DT_FEDIN] ? op1_gen_b : op1_gen_a;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         red_cnt_q <= '0;
      end else if (clk_en) begin
         if (!red_src) begin
            red_cnt_q <= '0;
         end else if (dt_tick && red_cnt_q != act_q[1]) begin
            red_cnt_q <= red_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fed_cnt_q <= '0;
      end else if (clk_en) begin
         if (fed_src) begin
            fed_cnt_q <= '0;
         end else if (dt_tick && fed_cnt_q != act_q[0]) begin
            fed_cnt_q <= fed_cnt_q + 1'b1;
         end
      end
   end

   assign red_o = (red_src & (red_cnt_q == act_q[1])) ^ dt_q[DT_REDINV];
   assign fed_o = (fed_src | (fed_cnt_q != act_q[0])) ^ dt_q[DT_FEDINV];
   assign path_a = red_o;
   assign path_b = dt_q[DT_DEB] ? (red_o & fed_o) : fed_o;
   assign dt_out[0] = dt_q[DT_ABYP] ? op1_gen_a
                    : (dt_q[DT_ASWAP] ? path_b : path_a);
   assign dt_out[1] = dt_q[DT_BBYP] ? op1_gen_b
                    : (dt_q[DT_BSWAP] ? path_a : path_b);

   // ==========================================
   // carrier chopper
   logic [3:0] pre_cnt_q;
   logic cr_tick;
   logic [2:0] phase_q;
   logic chop;
   logic period_end;
   logic [1:0] cr_out;

   assign cr_tick = clk_en & (pre_cnt_q == cr_q[CR_PRE_LSB +: 4]);
   assign chop = phase_q < cr_q[CR_DUTY_LSB +: 3];
   assign period_end = cr_tick & (phase_q == CR_LAST_PHASE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt_q <= 4'h0;
      end else if (cr_tick) begin
         pre_cnt_q <= 4'h0;
      end else if (clk_en) begin
         pre_cnt_q <= pre_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q <= 3'h0;
      end else if (cr_tick) begin
         phase_q <= phase_q + 3'h1;
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_car
      logic sin;
      logic prev_q;
      logic [3:0] fp_cnt_q;
      assign sin = dt_out[c] ^ cr_q[CR_IINV];
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            prev_q <= 1'b0;
            fp_cnt_q <= 4'h0;
         end else if (clk_en) begin
            prev_q <= sin;
            if (sin && !prev_q) begin
               fp_cnt_q <= cr_q[CR_FPW_LSB +: 4];
            end else if (!sin) begin
               fp_cnt_q <= 4'h0;
            end else if (period_end && fp_cnt_q != 4'h0) begin
               fp_cnt_q <= fp_cnt_q - 4'h1;
            end
         end
      end
      // bypass drops both inversions too
      assign cr_out[c] = cr_q[CR_EN]
         ? ((sin & ((fp_cnt_q != 4'h0) | chop)) ^ cr_q[CR_OINV])
         : dt_out[c];
   end

   // ==========================================
   // fault handler
   logic fost_prev_q;
   logic fcbc_prev_q;
   logic clr_prev_q;
   logic fost_tog;
   logic fcbc_tog;
   logic clr_tog;
   logic trig_ost;
   logic trig_cbc;
   logic cbc_refresh;

   assign fost_tog = ff_q[FF_FOST] ^ fost_prev_q;
   assign fcbc_tog = ff_q[FF_FCBC] ^ fcbc_prev_q;
   assign clr_tog = ff_q[FF_CLR] ^ clr_prev_q;
   assign trig_ost = (|(fault_input & fa_q[FA_OST_EN_LSB +: 3]))
                   | (fa_q[FA_SW_OST] & fost_tog);
   assign trig_cbc = (|(fault_input & fa_q[FA_CBC_EN_LSB +: 3]))
                   | (fa_q[FA_SW_CBC] & fcbc_tog);
   assign cbc_refresh =
      (ff_q[FF_REF_LSB] & timer_events.timer_equals_zero)
      | (ff_q[FF_REF_LSB+1] & timer_events.timer_equals_period);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fost_prev_q <= 1'b0;
         fcbc_prev_q <= 1'b0;
         clr_prev_q <= 1'b0;
      end else if (clk_en) begin
         fost_prev_q <= ff_q[FF_FOST];
         fcbc_prev_q <= ff_q[FF_FCBC];
         clr_prev_q <= ff_q[FF_CLR];
      end
   end

   // a new trip in the clearing cycle keeps the flag set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ost_on_q <= 1'b0;
      end else if (clk_en) begin
         if (trig_ost) begin
            ost_on_q <= 1'b1;
         end else if (clr_tog) begin
            ost_on_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cbc_on_q <= 1'b0;
      end else if (clk_en) begin
         if (trig_cbc) begin
            cbc_on_q <= 1'b1;
         end else if (cbc_refresh) begin
            cbc_on_q <= 1'b0;
         end
      end
   end

   logic [1:0] fh_out_q;

   for (genvar o = 0; o < 2; o++) begin : g_fh
      logic [7:0] f;
      logic [1:0] act;
      assign f = fa_q[FA_ACT_LSB + o*FA_ACT_STRIDE +: 8];
      always_comb begin
         act = ACT_HOLD;
         if (ost_on_q) begin
            act = timer_events.timer_up ? f[7:6] : f[5:4];
         end else if (cbc_on_q) begin
            act = timer_events.timer_up ? f[3:2] : f[1:0];
         end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            fh_out_q[o] <= 1'b0;
         end else if (clk_en) begin
            case (act)
               ACT_LOW: fh_out_q[o] <= 1'b0;
               ACT_HIGH: fh_out_q[o] <= 1'b1;
               ACT_TOGGLE: fh_out_q[o] <= ~cr_out[o];
               default: fh_out_q[o] <= cr_out[o];
            endcase
         end
      end
   end

   assign op1_output_a = fh_out_q[0];
   assign op1_output_b = fh_out_q[1];

   // ==========================================
   // generator trigger selection
   logic [1:0] trig_q;

   for (genvar t = 0; t < 2; t++) begin : g_trig
      logic [2:0] sel;
      assign sel = gt_q[(t == 0 ? GT_T0_LSB : GT_T1_LSB) +: 3];
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            trig_q[t] <= 1'b0;
         end else if (clk_en) begin
            if (sel < TRIG_SYNC) begin
               trig_q[t] <= fault_input[sel[1:0]];
            end else if (sel == TRIG_SYNC) begin
               trig_q[t] <= timer_events.sync_taken;
            end else begin
               trig_q[t] <= 1'b0;
            end
         end
      end
   end

   assign gen_trigger0 = trig_q[0];
   assign gen_trigger1 = trig_q[1];
endmodule

// [tb/pwmo_top_assertions.sv]
// assertions on pwmo_top ports
// assumes one ahb-lite master with an idle cycle between transfers
`timescale 1ns/1ps
module pwmo_top_assertions
   import pwmo_pkg::*;
#(
   parameter int VAL_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic [2:0] fault_input,
   input wire pwmo_timer_type timer_events,
   input wire logic gen_trigger0,
   input wire logic gen_trigger1,
   input wire logic [VAL_W-1:0] stamp_a_active,
   input wire logic [VAL_W-1:0] stamp_b_active,
   input wire logic gen_config_load
);
   // ==========================================
   // bus copies; data lands one edge after address
   logic take;
   logic wp_q;
   logic rz_q;
   logic aw_q;
   logic [7:0] wa_q;
   logic [31:0] gt_q;
   logic [31:0] su_q;
   logic [VAL_W-1:0] sa_q;
   logic src0;
   logic src1;
   assign take = hsel & htrans[1] & hready & clk_en;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q <= 1'b0;
         rz_q <= 1'b0;
         wa_q <= 8'h00;
      end else if (clk_en) begin
         wp_q <= take & hwrite;
         rz_q <= take & !hwrite & (haddr[7:0] < DT_CFG_OFF || haddr[7:0] > GT_CFG_OFF || haddr[1:0] != 2'h0);
         wa_q <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aw_q <= 1'b0;
         gt_q <= 32'h0;
         su_q <= 32'h0;
         sa_q <= '0;
      end else if (clk_en) begin
         aw_q <= wp_q && wa_q == STA_SHD_OFF;
         if (wp_q && wa_q == GT_CFG_OFF)
            gt_q <= hwdata;
         if (wp_q && wa_q == SU_CFG_OFF)
            su_q <= hwdata;
         if (wp_q && wa_q == STA_SHD_OFF)
            sa_q <= hwdata[VAL_W-1:0];
      end
   end
   // selection codes above sync mean no source
   assign src0 = gt_q[6:4] < 3'h3 ? fault_input[gt_q[5:4]] : gt_q[6:4] == TRIG_SYNC && timer_events.sync_taken;
   assign src1 = gt_q[9:7] < 3'h3 ? fault_input[gt_q[8:7]] : gt_q[9:7] == TRIG_SYNC && timer_events.sync_taken;
   // ==========================================
   // properties
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_trig0;
      clk_en |=> gen_trigger0 == $past(src0);
   endproperty
   a_trig0: assert property (p_trig0) else $error("trigger0 wrong");
   property p_trig1;
      clk_en |=> gen_trigger1 == $past(src1);
   endproperty
   a_trig1: assert property (p_trig1) else $error("trigger1 wrong");
   property p_stamp_src;
      $changed(stamp_a_active) |-> stamp_a_active == $past(sa_q);
   endproperty
   a_stamp_src: assert property (p_stamp_src) else $error("stamp a stale");
   property p_stamp_off;
      su_q[SU_A_LSB+UPM_OFF] |=> $stable(stamp_a_active);
   endproperty
   a_stamp_off: assert property (p_stamp_off) else $error("stamp a not blocked");
   property p_stampb_off;
      su_q[SU_B_LSB+UPM_OFF] |=> $stable(stamp_b_active);
   endproperty
   a_stampb_off: assert property (p_stampb_off) else $error("stamp b not blocked");
   property p_stamp_now;
      aw_q && su_q[3:0] == 4'h0 && clk_en |=> stamp_a_active == $past(sa_q);
   endproperty
   a_stamp_now: assert property (p_stamp_now) else $error("stamp a not loaded");
   property p_cfg_off;
      gt_q[GT_UP_LSB+UPM_OFF] |=> !gen_config_load;
   endproperty
   a_cfg_off: assert property (p_cfg_off) else $error("config not blocked");
   property p_unmapped;
      rz_q |-> hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// [tb/pwmo_top_bench.sv]
// self-checking bench for the pwm operator slice over ahb-lite
// assumes the slave's hreadyout is the bus hready; all on hclk
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module pwmo_top_bench
   import pwmo_pkg::*;
;
   localparam logic [31:0] WV [12] = '{32'h3ffff, 32'hffff, 32'hffff, 32'h3fff, 32'hffff00, 32'h1f,
      32'h0, 32'hff, 32'hffff, 32'hffff, 32'h3ff, 32'h0};
   localparam logic [7:0] UPM [6] = '{8'h00, 8'h11, 8'h22, 8'h44, 8'h88, 8'h33};
   localparam logic [2:0] EVT [6] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h7, 3'h2};
   localparam logic [2:0] BAD [6] = '{3'h0, 3'h3, 3'h5, 3'h6, 3'h0, 3'h1};
   logic hclk = 1'b0;
   logic hresetn, clk_en, hsel, hwrite, hreadyout, op1_gen_a, op1_gen_b, prescaled_timer_clock;
   logic op1_output_a, op1_output_b, gen_trigger0, gen_trigger1, gen_config_load;
   logic [1:0] htrans;
   logic [1:0] tk = 2'h0;
   logic [2:0] fault_input;
   logic [31:0] haddr, hwdata, hrdata, q, ffv;
   logic [15:0] stamp_a_active, stamp_b_active, sa, sb;
   pwmo_timer_type timer_events;
   int failures = 0;
   int checked = 0;
   int n0, n1, n2;
   always #25 hclk = ~hclk;
   // one timer tick every fourth cycle, phase known to the bench
   always @(posedge hclk) tk <= tk + 2'h1;
   always @(posedge hclk) prescaled_timer_clock <= (tk == 2'h3);
   pwmo_top #(.VAL_W(16)) uut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .op1_gen_a, .op1_gen_b, .fault_input,
      .prescaled_timer_clock, .timer_events, .op1_output_a, .op1_output_b, .gen_trigger0, .gen_trigger1,
      .stamp_a_active, .stamp_b_active, .gen_config_load);
   // ==========================================
   // bus and stimulus tasks
   task automatic complete_run();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         failures++;
         complete_run();
      end
   endtask
   // idle cycle first, for read-after-write
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   task automatic pulse(input logic [2:0] e, input logic [2:0] f);
      @(posedge hclk);
      timer_events[3:1] <= e;
      fault_input <= f;
      @(posedge hclk);
      timer_events[3:1] <= 3'h0;
      fault_input <= 3'h0;
      repeat (3) @(posedge hclk);
   endtask
   task automatic tgl(input int b);
      ffv[b] = ~ffv[b];
      wr(FF_CFG_OFF, ffv);
      repeat (3) @(posedge hclk);
   endtask
   task automatic rise(output int n);
      @(posedge hclk);
      op1_gen_a <= 1'b0;
      repeat (40) @(posedge hclk);
      while (tk != 2'h3) @(posedge hclk);
      op1_gen_a <= 1'b1;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (op1_output_a !== 1'b1 && n < 200);
      failures += int'(n >= 200);
   endtask
   task automatic cnt(input logic [31:0] cfg, input int e);
      int n;
      wr(CR_CFG_OFF, cfg);
      repeat (48) @(posedge hclk);
      n = 0;
      repeat (160) begin
         @(posedge hclk);
         n += int'(op1_output_a === 1'b1);
      end
      `CHK(n, e)
   endtask
   // ==========================================
   // main sequence
   initial begin
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      op1_gen_a = 1'b1;
      op1_gen_b = 1'b0;
      fault_input = 3'h0;
      timer_events = 4'h1;
      ffv = 32'h0;
      sa = 16'h0;
      sb = 16'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 12; i++)
         rdc(8'h90 + 8'(4 * i), i == 0 ? DT_CFG_RST : ZERO_RST);
      for (int i = 0; i < 12; i++)
         wr(8'h90 + 8'(4 * i), (i == 6 || i == 11) ? 32'hffffffff : WV[i]);
      for (int i = 0; i < 12; i++)
         rdc(8'h90 + 8'(4 * i), i == 7 ? 32'h3ff : WV[i]);
      for (int i = 0; i < 12; i++)
         wr(8'h90 + 8'(4 * i), 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(SU_CFG_OFF, {24'h0, UPM[i]});
         wr(STA_SHD_OFF, 32'h100 + 32'(i));
         wr(STB_SHD_OFF, 32'h200 + 32'(i));
         pulse(BAD[i], 3'h0);
         rdc(SU_CFG_OFF, {22'h0, i == 0 ? 2'h0 : 2'h3, UPM[i]});
         `CHK(stamp_a_active, i == 0 ? 16'h100 : sa)
         pulse(EVT[i], 3'h0);
         if (UPM[i] != 8'h88) begin
            sa = 16'h100 + 16'(i);
            sb = 16'h200 + 16'(i);
         end
         `CHK(stamp_a_active, sa)
         `CHK(stamp_b_active, sb)
         rdc(SU_CFG_OFF, {22'h0, UPM[i] == 8'h88 ? 2'h3 : 2'h0, UPM[i]});
      end
      for (int s = 0; s < 5; s++) begin
         wr(GT_CFG_OFF, 32'(s) << 4 | 32'(s) << 7);
         @(posedge hclk);
         fault_input <= (s < 3) ? 3'(1 << s) : 3'h0;
         timer_events[1] <= (s == 3);
         repeat (2) @(posedge hclk);
         `CHK(gen_trigger0, s < 4)
         `CHK(gen_trigger1, s < 4)
         fault_input <= 3'h0;
         timer_events[1] <= 1'b0;
      end
      wr(DT_CFG_OFF, DT_CFG_RST);
      pulse(3'h0, 3'h7);
      rdc(TS_OFF, 32'h0);
      for (int c = 0; c < 4; c++) begin
         wr(FA_CFG_OFF, 32'h10 | 32'(c) << 14 | 32'(c) << 22);
         pulse(3'h0, 3'h1);
         rdc(TS_OFF, 32'h2);
         `CHK(op1_output_a, c != 1 && c != 3)
         `CHK(op1_output_b, c > 1)
         tgl(FF_CLR);
         rdc(TS_OFF, 32'h0);
      end
      wr(FA_CFG_OFF, 32'h404);
      pulse(3'h0, 3'h4);
      rdc(TS_OFF, 32'h1);
      `CHK(op1_output_a, 1'b0)
      pulse(3'h4, 3'h0);
      rdc(TS_OFF, 32'h1);
      tgl(FF_REF_LSB);
      pulse(3'h2, 3'h0);
      rdc(TS_OFF, 32'h1);
      pulse(3'h4, 3'h0);
      rdc(TS_OFF, 32'h0);
      wr(FA_CFG_OFF, 32'h4811);
      pulse(3'h0, 3'h1);
      rdc(TS_OFF, 32'h3);
      `CHK(op1_output_a, 1'b0)
      tgl(FF_CLR);
      rdc(TS_OFF, 32'h1);
      pulse(3'h4, 3'h0);
      wr(FA_CFG_OFF, 32'h88);
      tgl(FF_FOST);
      rdc(TS_OFF, 32'h2);
      tgl(FF_CLR);
      tgl(FF_FOST);
      rdc(TS_OFF, 32'h2);
      tgl(FF_CLR);
      tgl(FF_FCBC);
      rdc(TS_OFF, 32'h1);
      pulse(3'h4, 3'h0);
      wr(FA_CFG_OFF, 32'h0);
      tgl(FF_FOST);
      rdc(TS_OFF, 32'h0);
      // dead time: differences cancel pipeline depth
      wr(DT_CFG_OFF, 32'h0);
      wr(RED_SHD_OFF, 32'h2);
      rise(n0);
      wr(RED_SHD_OFF, 32'h8);
      rise(n1);
      `CHK(n1 - n0, 6)
      wr(DT_CFG_OFF, 32'h80);
      wr(RED_SHD_OFF, 32'h2);
      rise(n2);
      `CHK(n2, n1)
      wr(DT_CFG_OFF, 32'h20000);
      wr(RED_SHD_OFF, 32'h8);
      rise(n1);
      wr(RED_SHD_OFF, 32'h2);
      rise(n0);
      `CHK(n1 - n0, 24)
      wr(DT_CFG_OFF, DT_CFG_RST);
      op1_gen_a <= 1'b0;
      cnt(32'h163, 0);
      cnt(32'h2163, 60);
      cnt(32'h3163, 100);
      cnt(32'h3000, 0);
      complete_run();
   end
endmodule
bind pwmo_top pwmo_top_assertions #(.VAL_W(VAL_W)) u_chk (.*);
